// >>> include/spc_pkg.sv
// constants shared by both ends of the sector protection link
// assumes a 250 MHz system clock on both ends
package spc_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ_PASSWORD    = 8'he7;
  localparam logic [7:0] OP_PROGRAM_PASSWORD = 8'he8;
  localparam logic [7:0] OP_UNLOCK_PASSWORD  = 8'he9;
  localparam logic [7:0] OP_READ_LOCK        = 8'ha7;
  localparam logic [7:0] OP_CLEAR_LOCK       = 8'ha6;
  localparam logic [7:0] OP_SET_FREEZE       = 8'h91;
  localparam logic [7:0] OP_READ_NV          = 8'hfc;
  localparam logic [7:0] OP_READ_NV_4B       = 8'he2;
  localparam logic [7:0] OP_PROGRAM_NV       = 8'hfd;
  localparam logic [7:0] OP_PROGRAM_NV_4B    = 8'he3;
  localparam logic [7:0] OP_ERASE_NV         = 8'he4;
  localparam logic [7:0] OP_READ_VOL         = 8'hfa;
  localparam logic [7:0] OP_READ_VOL_4B      = 8'he0;
  localparam logic [7:0] OP_WRITE_VOL        = 8'hfb;
  localparam logic [7:0] OP_WRITE_VOL_4B     = 8'he1;
  localparam logic [7:0] OP_READ_CONFIG      = 8'h2b;
  localparam logic [7:0] OP_PROGRAM_CONFIG   = 8'h2f;
  localparam logic [7:0] OP_READ_STATUS      = 8'h05;

  // ----------------------------------------------------------------
  // frame lengths in bytes, opcode included; LEN_ADDR3 and LEN_ADDR4 count address bytes only
  // ----------------------------------------------------------------
  localparam logic [3:0] LEN_ADDR3    = 4'h3;
  localparam logic [3:0] LEN_ADDR4    = 4'h4;
  localparam logic [3:0] LEN_SHORT    = 4'h1;
  localparam logic [3:0] LEN_PASSWORD = 4'h9;
  localparam logic [3:0] LEN_CONFIG   = 4'h3;

  // ----------------------------------------------------------------
  // register fields and reset values
  // ----------------------------------------------------------------
  localparam int          CFG_PERSIST_BIT  = 1;
  localparam int          CFG_PASSWORD_BIT = 2;
  localparam int          CFG_PARAM_BIT    = 15;
  localparam logic [15:0] CFG_RESET        = 16'hffff;
  localparam logic [1:0]  MODE_NONE        = 2'h3;
  localparam logic [1:0]  MODE_ILLEGAL     = 2'h0;
  localparam logic [63:0] PASSWORD_RESET   = 64'hffffffffffffffff;
  localparam int          LOCK_BIT         = 0;
  localparam int          FREEZE_BIT       = 7;
  localparam int          WIP_BIT          = 0;
  localparam int          PERR_BIT         = 6;
  localparam logic [7:0]  PROTECT_ON       = 8'h00;
  localparam logic [7:0]  PROTECT_OFF      = 8'hff;
  localparam int          NUM_SECT         = 16;
  localparam int          SECT_W           = 4;
  localparam int          SECT_LSB         = 16;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          PROG_TIME_NS  = 200000;
  localparam int          PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]  SCLK_DIV      = 5'h10;
  localparam logic [4:0]  SCLK_HALF     = 5'h08;

  // ----------------------------------------------------------------
  // host register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_TX_HI  = 8'h04;
  localparam logic [7:0] REG_TX_LO  = 8'h08;
  localparam logic [7:0] REG_RX_HI  = 8'h0c;
  localparam logic [7:0] REG_RX_LO  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

endpackage

// >>> include/spc_link_if.sv
// serial link between the protection controller host and the device
// assumes the host end drives clock, select and data in
`timescale 1ns/1ps
`default_nettype none
interface spc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;

  modport host   (output sclk, output cs_n, output mosi, input miso);
  modport device (input sclk, input cs_n, input mosi, output miso);
endinterface
`default_nettype wire

// >>> rtl/spc_device.sv
// device end: protection configuration, password, lock, freeze, sector bits
// assumes the link pins are asynchronous; sampled by sys_clk
// Functional notes
// [R01] mode bits 11: persistent mode, factory default
// [R02] 10 selects persistent, 01 selects password
// [R03] programming both mode bits zero: abort, error
// [R04] mode bits frozen once chosen; retry errors
// [R05] host writes password before password mode bit
// [R06] config program busy like page program, polled
// [R07] parameter bit programmable while freeze is zero
// [R08] parameter bit 0 top, 1 bottom
// [R09] parameter bit one-time; never returns to 1
// [R10] host sets parameter bit before array use
// [R11] 64-bit password unreadable in password mode
// [R12] lock 0 guards nv bits; clear command
// [R13] persistent: reset sets lock; no soft set
// [R14] password: reset clears lock; unlock sets
// [R15] unlock sets lock only on password match
// [R16] freeze rejects parameter and protected area writes; code rejects only parameter bit writes
// [R17] freeze volatile, set by command, hard reset
// [R18] password opcodes e7, e8, e9
// [R19] lock opcodes a7, a6, 91
// [R20] nv opcodes fc/e2, fd/e3, e4
// [R21] nv bit reads 00 protected, ff free
// [R22] volatile bit reads 00/ff, default ff
// [R23] sector protected if either bit zero
`timescale 1ns/1ps
`default_nettype none
module spc_device #(
  parameter int unsigned PROG_CYCLES = spc_pkg::PROG_CYCLES
) (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  spc_link_if.device                        link,
  input  wire logic                         hard_reset,
  input  wire logic                         soft_reset,
  output logic [spc_pkg::NUM_SECT-1:0]      sector_protected,
  output logic                              param_block_top,
  output logic                              freeze,
  output logic                              write_in_progress
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0]  sclk_s_r, cs_s_r;
  logic [1:0]  mosi_s_r;
  logic [2:0]  bit_cnt_r, bit_cnt_nxt;
  logic [7:0]  shin_r, shin_nxt;
  logic [3:0]  nbytes_r, nbytes_nxt;
  logic [7:0]  op_r, op_nxt;
  logic [63:0] rx_r, rx_nxt;
  logic [7:0]  out_r, out_nxt;
  logic [63:0] resp_r, resp_nxt;
  logic        miso_r, miso_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [63:0] pwd_r, pwd_nxt;
  logic        lock_r, lock_nxt;
  logic        freeze_r, freeze_nxt;
  logic        perr_r, perr_nxt;
  logic [31:0] busy_r, busy_nxt;
  logic        wip_r;
  logic        top_r;
  logic [spc_pkg::NUM_SECT-1:0] nv_r, nv_nxt, vol_r, vol_nxt, prot_r, prot_nxt;

  logic        rise, fall, cs_rise, active, byte_done, pwd_mode, busy, is4b, rd_addr;
  logic        start_prog, cfg_err;
  logic [7:0]  byte_in;
  logic [3:0]  alen;
  logic [31:0] addr_now;
  logic [63:0] w;
  logic [15:0] cfg_new;
  logic [spc_pkg::SECT_W-1:0] sect_rd, sect_pg, sect_wr;

  assign rise      = sclk_s_r[1] & ~sclk_s_r[2];
  assign fall      = ~sclk_s_r[1] & sclk_s_r[2];
  assign cs_rise   = cs_s_r[1] & ~cs_s_r[2];
  assign active    = ~cs_s_r[1];
  assign byte_done = rise & active & (bit_cnt_r == 3'h7);
  assign byte_in   = {shin_r[6:0], mosi_s_r[1]};
  assign pwd_mode  = ~cfg_r[spc_pkg::CFG_PASSWORD_BIT];
  assign busy      = (busy_r != 32'h0);
  assign is4b      = (op_r == spc_pkg::OP_READ_NV_4B) || (op_r == spc_pkg::OP_READ_VOL_4B) ||
                     (op_r == spc_pkg::OP_PROGRAM_NV_4B) || (op_r == spc_pkg::OP_WRITE_VOL_4B);
  assign alen      = is4b ? spc_pkg::LEN_ADDR4 : spc_pkg::LEN_ADDR3;
  assign rd_addr   = (op_r == spc_pkg::OP_READ_NV) || (op_r == spc_pkg::OP_READ_NV_4B) ||
                     (op_r == spc_pkg::OP_READ_VOL) || (op_r == spc_pkg::OP_READ_VOL_4B);
  assign addr_now  = {rx_r[23:0], byte_in};
  assign sect_rd   = addr_now[spc_pkg::SECT_LSB +: spc_pkg::SECT_W];
  assign sect_pg   = rx_r[spc_pkg::SECT_LSB +: spc_pkg::SECT_W];
  assign sect_wr   = rx_r[spc_pkg::SECT_LSB + 8 +: spc_pkg::SECT_W];
  assign cfg_new   = {rx_r[7:0], rx_r[15:8]};

  // ----------------------------------------------------------------
  // per-sector protection
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < spc_pkg::NUM_SECT; gi++)
    begin : g_sect
      assign prot_nxt[gi] = ~(nv_r[gi] & vol_r[gi]); // [R23]
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    bit_cnt_nxt = bit_cnt_r;
    shin_nxt    = shin_r;
    nbytes_nxt  = nbytes_r;
    op_nxt      = op_r;
    rx_nxt      = rx_r;
    out_nxt     = out_r;
    resp_nxt    = resp_r;
    miso_nxt    = miso_r;
    cfg_nxt     = cfg_r;
    pwd_nxt     = pwd_r;
    lock_nxt    = lock_r;
    freeze_nxt  = freeze_r;
    perr_nxt    = perr_r;
    nv_nxt      = nv_r;
    vol_nxt     = vol_r;
    busy_nxt    = busy ? busy_r - 32'h1 : busy_r; // [R06]
    start_prog  = 1'b0;
    cfg_err     = 1'b0;
    w           = spc_pkg::PASSWORD_RESET;

    if (rise && active)
    begin
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      shin_nxt    = byte_in;
    end
    if (fall && active)
    begin
      miso_nxt = out_r[7];
      out_nxt  = {out_r[6:0], 1'b1};
    end
    if (byte_done)
    begin
      nbytes_nxt = (nbytes_r == 4'hf) ? nbytes_r : nbytes_r + 4'h1;
      resp_nxt   = {resp_r[55:0], 8'hff};
      out_nxt    = resp_r[63:56];
      if (nbytes_r == 4'h0)
      begin
        op_nxt = byte_in;
        unique case (byte_in)
          spc_pkg::OP_READ_PASSWORD: w = pwd_mode ? spc_pkg::PASSWORD_RESET : pwd_r; // [R11] [R18]
          spc_pkg::OP_READ_LOCK:     w = {freeze_r, 6'h0, lock_r, 56'hffffffffffffff}; // [R19]
          spc_pkg::OP_READ_CONFIG:   w = {cfg_r[7:0], cfg_r[15:8], 48'hffffffffffff};
          spc_pkg::OP_READ_STATUS:   w = {1'b0, perr_r, 5'h0, busy, 56'hffffffffffffff}; // [R06]
          default:                   w = spc_pkg::PASSWORD_RESET;
        endcase
        out_nxt  = w[63:56];
        resp_nxt = {w[55:0], 8'hff};
      end
      else
      begin
        rx_nxt = {rx_r[55:0], byte_in};
        if (rd_addr && (nbytes_r == alen))
        begin
          if ((op_r == spc_pkg::OP_READ_NV) || (op_r == spc_pkg::OP_READ_NV_4B)) // [R20]
            out_nxt = nv_r[sect_rd] ? spc_pkg::PROTECT_OFF : spc_pkg::PROTECT_ON; // [R21]
          else
            out_nxt = vol_r[sect_rd] ? spc_pkg::PROTECT_OFF : spc_pkg::PROTECT_ON; // [R22]
        end
      end
    end

    // commands take effect when select goes high; ignored while busy
    if (cs_rise && !busy)
    begin
      unique case (op_r)
        spc_pkg::OP_CLEAR_LOCK:
          if (nbytes_r == spc_pkg::LEN_SHORT)
            lock_nxt = 1'b0; // [R12] [R19]
        spc_pkg::OP_SET_FREEZE:
          if (nbytes_r == spc_pkg::LEN_SHORT)
            freeze_nxt = 1'b1; // [R17]
        spc_pkg::OP_ERASE_NV:
          if (nbytes_r == spc_pkg::LEN_SHORT)
          begin
            if (lock_r)
            begin
              nv_nxt     = '1; // [R12] [R20]
              start_prog = 1'b1;
            end
            else
              perr_nxt = 1'b1;
          end
        spc_pkg::OP_PROGRAM_NV, spc_pkg::OP_PROGRAM_NV_4B:
          if (nbytes_r == alen + 4'h1)
          begin
            if (lock_r)
            begin
              nv_nxt[sect_pg] = 1'b0; // [R12]
              start_prog      = 1'b1;
            end
            else
              perr_nxt = 1'b1;
          end
        spc_pkg::OP_WRITE_VOL, spc_pkg::OP_WRITE_VOL_4B:
          if (nbytes_r == alen + 4'h2)
            vol_nxt[sect_wr] = (rx_r[7:0] == spc_pkg::PROTECT_OFF); // [R22]
        spc_pkg::OP_PROGRAM_PASSWORD:
          if (nbytes_r == spc_pkg::LEN_PASSWORD)
          begin
            if (pwd_mode)
              perr_nxt = 1'b1;
            else
            begin
              pwd_nxt    = pwd_r & rx_r;
              start_prog = 1'b1;
            end
          end
        spc_pkg::OP_UNLOCK_PASSWORD:
          if ((nbytes_r == spc_pkg::LEN_PASSWORD) && pwd_mode && (rx_r == pwd_r))
            lock_nxt = 1'b1; // [R14] [R15]
        spc_pkg::OP_PROGRAM_CONFIG:
          if (nbytes_r == spc_pkg::LEN_CONFIG)
          begin
            cfg_err = (cfg_new[2:1] == spc_pkg::MODE_ILLEGAL) || // [R03]
                      ((cfg_r[2:1] != spc_pkg::MODE_NONE) && (cfg_new[2:1] != cfg_r[2:1])) || // [R04]
                      (freeze_r && cfg_r[spc_pkg::CFG_PARAM_BIT] &&
                       !cfg_new[spc_pkg::CFG_PARAM_BIT]); // [R07] [R16]
            if (cfg_err)
              perr_nxt = 1'b1;
            else
            begin
              cfg_nxt[2:1] = cfg_r[2:1] & cfg_new[2:1]; // [R02]
              cfg_nxt[spc_pkg::CFG_PARAM_BIT] = cfg_r[spc_pkg::CFG_PARAM_BIT] &
                                                cfg_new[spc_pkg::CFG_PARAM_BIT]; // [R09]
              start_prog = 1'b1;
            end
          end
        default:
          begin
          end
      endcase
    end
    if (start_prog)
    begin
      busy_nxt = PROG_CYCLES; // [R06]
      perr_nxt = 1'b0;
    end
    if (!active || soft_reset)
    begin
      bit_cnt_nxt = 3'h0;
      nbytes_nxt  = 4'h0;
    end
    if (hard_reset)
    begin
      lock_nxt    = cfg_r[spc_pkg::CFG_PASSWORD_BIT]; // [R13] [R14]
      freeze_nxt  = 1'b0; // [R17]
      vol_nxt     = '1;
      bit_cnt_nxt = 3'h0;
      nbytes_nxt  = 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_s_r  <= 3'h0;
      cs_s_r    <= 3'h7;
      mosi_s_r  <= 2'h0;
      bit_cnt_r <= 3'h0;
      shin_r    <= 8'h0;
      nbytes_r  <= 4'h0;
      op_r      <= 8'h0;
      rx_r      <= 64'h0;
      out_r     <= 8'hff;
      resp_r    <= 64'h0;
      miso_r    <= 1'b1;
      cfg_r     <= spc_pkg::CFG_RESET; // [R01]
      pwd_r     <= spc_pkg::PASSWORD_RESET;
      lock_r    <= 1'b1; // [R13]
      freeze_r  <= 1'b0; // [R17]
      perr_r    <= 1'b0;
      busy_r    <= 32'h0;
      wip_r     <= 1'b0;
      top_r     <= 1'b0;
      nv_r      <= '1;
      vol_r     <= '1;
      prot_r    <= '0;
    end
    else
    begin
      sclk_s_r  <= {sclk_s_r[1:0], link.sclk};
      cs_s_r    <= {cs_s_r[1:0], link.cs_n};
      mosi_s_r  <= {mosi_s_r[0], link.mosi};
      bit_cnt_r <= bit_cnt_nxt;
      shin_r    <= shin_nxt;
      nbytes_r  <= nbytes_nxt;
      op_r      <= op_nxt;
      rx_r      <= rx_nxt;
      out_r     <= out_nxt;
      resp_r    <= resp_nxt;
      miso_r    <= miso_nxt;
      cfg_r     <= cfg_nxt;
      pwd_r     <= pwd_nxt;
      lock_r    <= lock_nxt;
      freeze_r  <= freeze_nxt;
      perr_r    <= perr_nxt;
      busy_r    <= busy_nxt;
      wip_r     <= (busy_nxt != 32'h0);
      top_r     <= ~cfg_r[spc_pkg::CFG_PARAM_BIT]; // [R08]
      nv_r      <= nv_nxt;
      vol_r     <= vol_nxt;
      prot_r    <= prot_nxt;
    end
  end

  assign link.miso        = miso_r;
  assign sector_protected = prot_r;
  assign param_block_top  = top_r;
  assign freeze           = freeze_r;
  assign write_in_progress              = wip_r;

endmodule
`default_nettype wire

// >>> rtl/spc_host.sv
// host end: register port in, serial frames out to the protection device
// assumes software follows the frame layout and polls device status itself
`timescale 1ns/1ps
`default_nettype none
module spc_host (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  spc_link_if.host         link,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic [31:0]      reg_rdata
);

  typedef enum logic [2:0] {
    SPC_IDLE  = 3'b001,
    SPC_SHIFT = 3'b010,
    SPC_GAP   = 3'b100
  } spc_state_e;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spc_state_e  st_r, st_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic [63:0] tx_r, tx_nxt, rx_r, rx_nxt;
  logic [71:0] sh_r, sh_nxt;
  logic [7:0]  left_r, left_nxt;
  logic [4:0]  div_r, div_nxt;
  logic        sclk_r, sclk_nxt, cs_r, cs_nxt, mosi_r, mosi_nxt;
  logic [1:0]  miso_s_r;
  logic [31:0] rd_r, rd_nxt;
  logic [71:0] frame;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt   = st_r;
    cmd_nxt  = cmd_r;
    tx_nxt   = tx_r;
    rx_nxt   = rx_r;
    sh_nxt   = sh_r;
    left_nxt = left_r;
    div_nxt  = div_r;
    sclk_nxt = sclk_r;
    cs_nxt   = cs_r;
    mosi_nxt = mosi_r;
    rd_nxt   = 32'h0;
    frame    = {reg_wdata[7:0], tx_r};

    if (reg_re)
    begin
      unique case (reg_addr)
        spc_pkg::REG_CMD:    rd_nxt = {16'h0, cmd_r};
        spc_pkg::REG_TX_HI:  rd_nxt = tx_r[63:32];
        spc_pkg::REG_TX_LO:  rd_nxt = tx_r[31:0];
        spc_pkg::REG_RX_HI:  rd_nxt = rx_r[63:32];
        spc_pkg::REG_RX_LO:  rd_nxt = rx_r[31:0];
        spc_pkg::REG_STATUS: rd_nxt = {31'h0, (st_r != SPC_IDLE)};
        default:             rd_nxt = 32'h0;
      endcase
    end

    unique case (st_r)
      SPC_IDLE:
        if (reg_we)
        begin
          if (reg_addr == spc_pkg::REG_TX_HI)
            tx_nxt[63:32] = reg_wdata;
          if (reg_addr == spc_pkg::REG_TX_LO)
            tx_nxt[31:0] = reg_wdata;
          if (reg_addr == spc_pkg::REG_CMD)
          begin
            // opcode, then tx bytes, then rx bytes; every bit samples miso
            cmd_nxt  = reg_wdata[15:0];
            left_nxt = ({4'h0, reg_wdata[11:8]} + {4'h0, reg_wdata[15:12]} + 8'h1) << 3;
            mosi_nxt = frame[71];
            sh_nxt   = {frame[70:0], 1'b1};
            rx_nxt   = 64'h0;
            cs_nxt   = 1'b0;
            sclk_nxt = 1'b0;
            div_nxt  = 5'h0;
            st_nxt   = SPC_SHIFT;
          end
        end
      SPC_SHIFT:
        begin
          div_nxt = div_r + 5'h1;
          if (div_r == spc_pkg::SCLK_HALF - 5'h1)
            sclk_nxt = 1'b1;
          if (div_r == spc_pkg::SCLK_DIV - 5'h1)
          begin
            // sample at the end of the high phase for synchroniser margin
            sclk_nxt = 1'b0;
            div_nxt  = 5'h0;
            rx_nxt   = {rx_r[62:0], miso_s_r[1]};
            left_nxt = left_r - 8'h1;
            if (left_r == 8'h1)
            begin
              cs_nxt = 1'b1;
              st_nxt = SPC_GAP;
            end
            else
            begin
              mosi_nxt = sh_r[71];
              sh_nxt   = {sh_r[70:0], 1'b1};
            end
          end
        end
      SPC_GAP:
        begin
          div_nxt = div_r + 5'h1;
          if (div_r == spc_pkg::SCLK_DIV - 5'h1)
          begin
            div_nxt = 5'h0;
            st_nxt  = SPC_IDLE;
          end
        end
      default:
        st_nxt = SPC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r     <= SPC_IDLE;
      cmd_r    <= 16'h0;
      tx_r     <= 64'h0;
      rx_r     <= 64'h0;
      sh_r     <= 72'h0;
      left_r   <= 8'h0;
      div_r    <= 5'h0;
      sclk_r   <= 1'b0;
      cs_r     <= 1'b1;
      mosi_r   <= 1'b1;
      miso_s_r <= 2'h3;
      rd_r     <= 32'h0;
    end
    else
    begin
      st_r     <= st_nxt;
      cmd_r    <= cmd_nxt;
      tx_r     <= tx_nxt;
      rx_r     <= rx_nxt;
      sh_r     <= sh_nxt;
      left_r   <= left_nxt;
      div_r    <= div_nxt;
      sclk_r   <= sclk_nxt;
      cs_r     <= cs_nxt;
      mosi_r   <= mosi_nxt;
      miso_s_r <= {miso_s_r[0], link.miso};
      rd_r     <= rd_nxt;
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_r;
  assign link.mosi = mosi_r;
  assign reg_rdata = rd_r;

endmodule
`default_nettype wire

// >>> test/spc_link_props.sv
// checker for the serial link: clock shape, framing, data hold
// assumes the host end derives sclk from sys_clk
`timescale 1ns/1ps
`default_nettype none
module spc_link_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  // ----------------------------------------------------------------
  // link rules
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_reset_idle: assert property ($rose(rst_n) |-> cs_n && !sclk && miso)
    else $error("link not idle after reset");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("sclk moves outside a frame");
  a_high_len: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("sclk high phase length wrong");
  a_low_len: assert property ($fell(sclk) |-> !sclk[*8])
    else $error("sclk low phase too short");
  a_first_rise: assert property ($fell(cs_n) |-> !sclk[*8])
    else $error("first sclk rise too early");
  a_select_gap: assert property ($rose(cs_n) |-> cs_n[*8] ##1 cs_n[*8])
    else $error("gap between frames too short");
  a_mosi_hold: assert property (sclk |-> $stable(mosi))
    else $error("mosi changed while sclk high");
  a_miso_hold: assert property (!cs_n && sclk |-> $stable(miso))
    else $error("miso changed while sclk high");
  cover property ($rose(cs_n));
  cover property (!cs_n && $fell(miso));
  cover property ($rose(sclk) && mosi);
endmodule
`default_nettype wire

// >>> test/sector_protection_control_tb.sv
// bench: register port of the host end drives frames into the device end
// assumes package, link interface and both design ends compiled first
`timescale 1ns/1ps
`default_nettype none
module sector_protection_control_tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hard_reset = 1'b0;
  logic        soft_reset = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [31:0] reg_rdata, r, x;
  logic [31:0] seed = 32'hea17;
  logic [63:0] pw;
  logic [15:0] sector_protected;
  logic        param_block_top, freeze, write_in_progress;
  logic [3:0]  s, t;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  spc_link_if i_spc_link_if();
  spc_host i_spc_host (.sys_clk(sys_clk), .rst_n(rst_n), .link(i_spc_link_if.host),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata));
  // short program time keeps the run brief and ends before the next status poll reads busy
  spc_device #(.PROG_CYCLES(100)) i_spc_device (.sys_clk(sys_clk), .rst_n(rst_n),
    .link(i_spc_link_if.device), .hard_reset(hard_reset), .soft_reset(soft_reset),
    .sector_protected(sector_protected), .param_block_top(param_block_top),
    .freeze(freeze), .write_in_progress(write_in_progress));
  spc_link_props i_spc_link_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .sclk(i_spc_link_if.sclk), .cs_n(i_spc_link_if.cs_n), .mosi(i_spc_link_if.mosi),
    .miso(i_spc_link_if.miso));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [7:0] pb(input logic p);
    return p ? 8'h00 : 8'hff;
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    // generous ceiling: whole sequence needs well under half of it
    if (cyc == 90000)
    begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge sys_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge sys_clk);
    reg_re <= 1'b0;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic xf(input logic [7:0] op, input logic [3:0] tx, input logic [3:0] rx,
                    input logic [31:0] hi, input logic [31:0] lo, output logic [31:0] d);
    wr(8'h04, hi);
    wr(8'h08, lo);
    wr(8'h00, {16'h0, rx, tx, op});
    d = 32'h1;
    repeat (3000) if (d[0] === 1'b1) rd(8'h14, d);
    rd(8'h10, d);
  endtask
  task automatic st(input logic [7:0] e);
    logic [31:0] q;
    xf(8'h05, 4'h0, 4'h1, 32'h0, 32'h0, q);
    chk(q[7:0], e);
  endtask
  task automatic pl(input logic h);
    @(posedge sys_clk);
    hard_reset <= h;
    soft_reset <= !h;
    @(posedge sys_clk);
    hard_reset <= 1'b0;
    soft_reset <= 1'b0;
    @(posedge sys_clk);
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    seed = xs(seed);
    s = seed[3:0];
    t = s + 4'h1;
    pw = {xs(seed), seed};
    xf(8'ha7, 4'h0, 4'h1, 32'h0, 32'h0, r);
    chk(r[7:0], 8'h01);
    xf(8'hfc, 4'h3, 4'h1, {4'h0, s, 24'h0}, 32'h0, r);
    chk(r[7:0], pb(1'b0));
    xf(8'hfd, 4'h3, 4'h0, {4'h0, s, 24'h0}, 32'h0, r);
    chk(write_in_progress, 1'b1);
    st(8'h00);
    xf(8'he2, 4'h4, 4'h1, {12'h0, s, 16'h0}, 32'h0, r);
    chk(r[7:0], pb(1'b1));
    xf(8'hfb, 4'h4, 4'h0, {4'h0, t, 24'h0}, 32'h0, r);
    xf(8'hfa, 4'h3, 4'h1, {4'h0, t, 24'h0}, 32'h0, r);
    chk(r[7:0], pb(1'b1));
    chk(sector_protected, (16'h1 << s) | (16'h1 << t));
    xf(8'he4, 4'h0, 4'h0, 32'h0, 32'h0, r);
    st(8'h00);
    chk(sector_protected, 16'h1 << t);
    pl(1'b1);
    xf(8'he0, 4'h4, 4'h1, {12'h0, t, 16'h0}, 32'h0, r);
    chk(r[7:0], pb(1'b0));
    xf(8'ha6, 4'h0, 4'h0, 32'h0, 32'h0, r);
    xf(8'ha7, 4'h0, 4'h1, 32'h0, 32'h0, r);
    chk(r[7:0], 8'h00);
    xf(8'he3, 4'h4, 4'h0, {12'h0, s, 16'h0}, 32'h0, r);
    st(8'h40);
    chk(sector_protected, 16'h0);
    pl(1'b1);
    xf(8'ha7, 4'h0, 4'h1, 32'h0, 32'h0, r);
    chk(r[7:0], 8'h01);
    xf(8'he4, 4'h0, 4'h0, 32'h0, 32'h0, r);
    st(8'h00);
    xf(8'h2b, 4'h0, 4'h2, 32'h0, 32'h0, r);
    chk(r[15:0], 16'hffff);
    xf(8'h91, 4'h0, 4'h0, 32'h0, 32'h0, r);
    pl(1'b0);
    xf(8'h2f, 4'h2, 4'h0, 32'hff7f0000, 32'h0, r);
    st(8'h40);
    chk(param_block_top, 1'b0);
    xf(8'ha7, 4'h0, 4'h1, 32'h0, 32'h0, r);
    chk(r[7:0], 8'h81);
    pl(1'b1);
    chk(freeze, 1'b0);
    xf(8'he8, 4'h8, 4'h0, pw[63:32], pw[31:0], r);
    st(8'h00);
    xf(8'he7, 4'h0, 4'h8, 32'h0, 32'h0, r);
    rd(8'h0c, x);
    chk({x, r}, pw);
    xf(8'h2f, 4'h2, 4'h0, 32'hf9ff0000, 32'h0, r);
    st(8'h40);
    xf(8'h2f, 4'h2, 4'h0, 32'hfbff0000, 32'h0, r);
    st(8'h00);
    xf(8'h2f, 4'h2, 4'h0, 32'hfb7f0000, 32'h0, r);
    chk(param_block_top, 1'b1);
    xf(8'h2f, 4'h2, 4'h0, 32'hfbff0000, 32'h0, r);
    chk(param_block_top, 1'b1);
    xf(8'h2f, 4'h2, 4'h0, 32'hfd7f0000, 32'h0, r);
    st(8'h40);
    xf(8'h2b, 4'h0, 4'h2, 32'h0, 32'h0, r);
    chk(r[15:0], 16'hfb7f);
    xf(8'he7, 4'h0, 4'h8, 32'h0, 32'h0, r);
    rd(8'h0c, x);
    chk({x, r}, {64{1'b1}});
    pl(1'b1);
    xf(8'ha7, 4'h0, 4'h1, 32'h0, 32'h0, r);
    chk(r[7:0], 8'h00);
    xf(8'he9, 4'h8, 4'h0, pw[63:32], pw[31:0] ^ 32'h1, r);
    xf(8'ha7, 4'h0, 4'h1, 32'h0, 32'h0, r);
    chk(r[7:0], 8'h00);
    xf(8'he9, 4'h8, 4'h0, pw[63:32], pw[31:0], r);
    xf(8'ha7, 4'h0, 4'h1, 32'h0, 32'h0, r);
    chk(r[7:0], 8'h01);
    close_out();
  end
endmodule
`default_nettype wire
